// ===== core/rmvc_pkg.sv
// Overview of operation
// - Core rail control at offset 37h resets to 0Ah; all fields read/write.
// - In standby, set point code 1/2/3 lowers rail 4/3/2 percent; 0 keeps normal.
// - Voltage select bits 5-4, reset 0: 1.05 V, 1 V, 0.975 V, 0.95 V.
// - On standby exit, nonzero exit-mode bits 3-2 are copied into mode control.
// - Mode control bits 1-0 reset 2: off, auto, auto, forced PWM.
// - Five volt rail register at 38h resets to 2Ah and is read-only.
// - Standby is active low; cleared override forces auto over forced PWM in standby.
package rmvc_pkg;
   localparam logic [7:0] CORE_RAIL_CONTROL_ADDR = 8'h37;
   localparam logic [7:0] FIVE_VOLT_RAIL_CONTROL_ADDR = 8'h38;
   localparam logic [7:0] CORE_RAIL_CONTROL_RST = 8'h0A;
   localparam logic [7:0] FIVE_VOLT_RAIL_CONTROL_RST = 8'h2A;
   localparam int LOW_POWER_SETPOINT_LSB = 6;
   localparam int VOLTAGE_SELECT_LSB = 4;
   localparam int EXIT_STANDBY_MODE_LSB = 2;
   localparam int MODE_CONTROL_LSB = 0;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_AUTO = 2'h2;
   localparam logic [1:0] MODE_FORCED_PWM = 2'h3;
   localparam logic [1:0] EXIT_NO_CHANGE = 2'h0;
   // Effective set point in units of 0.5 percent offset from nominal (signed).
   localparam logic signed [4:0] SETPOINT_P5 = 5'sh0A;
   localparam logic signed [4:0] SETPOINT_NOM = 5'sh00;
   localparam logic signed [4:0] SETPOINT_M2P5 = -5'sh05;
   localparam logic signed [4:0] SETPOINT_M5 = -5'sh0A;
   localparam logic signed [4:0] SETPOINT_M4 = -5'sh08;
   localparam logic signed [4:0] SETPOINT_M3 = -5'sh06;
   localparam logic signed [4:0] SETPOINT_M2 = -5'sh04;
endpackage

// ===== core/rmvc_sync.sv
module rmvc_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic d,
   output logic q
);
   logic meta_r;

   // Reset to the idle (not in standby) level of an active-low input.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_r <= 1'b1;
         q <= 1'b1;
      end
      else
      begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// ===== core/rmvc_regs.sv
module rmvc_regs (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   input wire logic standby_n,
   input wire logic core_low_power_override,
   output logic [1:0] core_mode_effective,
   output logic core_converter_enable,
   output logic core_forced_pwm,
   output logic signed [4:0] core_setpoint_half_pct,
   output logic [1:0] core_exit_standby_mode_q,
   output logic [7:0] core_rail_control_q
);
   logic standby_n_s;
   logic standby_n_d_r;
   logic [7:0] core_rail_control_r;
   logic standby_exit;
   logic in_standby;
   logic [1:0] ctl;
   logic [1:0] exit_mode;
   logic [1:0] lvsel;
   logic [1:0] vsel;
   logic [1:0] mode_nxt;
   logic signed [4:0] setpoint_nxt;
   logic core_wr_hit;
   logic exit_copy_en;
   logic [1:0] mode_r;
   logic signed [4:0] setpoint_r;
   logic [7:0] rdata_nxt;
   logic hit_nxt;
   logic [7:0] rdata_r;
   logic hit_r;

   function automatic logic signed [4:0] vsel_offset(input logic [1:0] code);
      case (code)
         2'h0: vsel_offset = rmvc_pkg::SETPOINT_P5;
         2'h1: vsel_offset = rmvc_pkg::SETPOINT_NOM;
         2'h2: vsel_offset = rmvc_pkg::SETPOINT_M2P5;
         default: vsel_offset = rmvc_pkg::SETPOINT_M5;
      endcase
   endfunction

   // The core address decode is shared by the write and read paths; the five volt decode serves the read path only.
   function automatic logic is_core_addr(input logic [7:0] addr);
      is_core_addr = addr == rmvc_pkg::CORE_RAIL_CONTROL_ADDR;
   endfunction

   function automatic logic is_five_addr(input logic [7:0] addr);
      is_five_addr = addr == rmvc_pkg::FIVE_VOLT_RAIL_CONTROL_ADDR;
   endfunction

   rmvc_sync u_standby_sync (
      .clk(clk),
      .rst(rst),
      .d(standby_n),
      .q(standby_n_s)
   );

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         standby_n_d_r <= 1'b1;
      else
         standby_n_d_r <= standby_n_s;
   end

   assign in_standby = ~standby_n_s;
   assign standby_exit = standby_n_s & ~standby_n_d_r;

   assign lvsel = core_rail_control_r[rmvc_pkg::LOW_POWER_SETPOINT_LSB +: 2];
   assign vsel = core_rail_control_r[rmvc_pkg::VOLTAGE_SELECT_LSB +: 2];
   assign exit_mode = core_rail_control_r[rmvc_pkg::EXIT_STANDBY_MODE_LSB +: 2];
   assign ctl = core_rail_control_r[rmvc_pkg::MODE_CONTROL_LSB +: 2];

   // Writes to the five volt address never reach a register, so they vanish here.
   assign core_wr_hit = reg_wr && is_core_addr(reg_addr);
   assign exit_copy_en = standby_exit && exit_mode != rmvc_pkg::EXIT_NO_CHANGE;

   // A software write in the exit cycle wins over the hardware copy for the whole byte.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         core_rail_control_r <= rmvc_pkg::CORE_RAIL_CONTROL_RST;
      else if (core_wr_hit)
         core_rail_control_r <= reg_wdata;
      else if (exit_copy_en)
         core_rail_control_r[rmvc_pkg::MODE_CONTROL_LSB +: 2] <= exit_mode;
   end

   always_comb
   begin
      mode_nxt = ctl;
      if (in_standby && !core_low_power_override && ctl == rmvc_pkg::MODE_FORCED_PWM)
         mode_nxt = rmvc_pkg::MODE_AUTO;
      setpoint_nxt = vsel_offset(vsel);
      if (in_standby)
      begin
         case (lvsel)
            2'h1: setpoint_nxt = rmvc_pkg::SETPOINT_M4;
            2'h2: setpoint_nxt = rmvc_pkg::SETPOINT_M3;
            2'h3: setpoint_nxt = rmvc_pkg::SETPOINT_M2;
            default: setpoint_nxt = vsel_offset(vsel);
         endcase
      end
   end

   // The effective mode is registered so the converter never sees a decode glitch.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         mode_r <= rmvc_pkg::MODE_AUTO;
      else
         mode_r <= mode_nxt;
   end

   // The set point follows the same one-cycle latency as the mode.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         setpoint_r <= rmvc_pkg::SETPOINT_P5;
      else
         setpoint_r <= setpoint_nxt;
   end

   assign core_mode_effective = mode_r;
   assign core_setpoint_half_pct = setpoint_r;
   assign core_converter_enable = mode_r != rmvc_pkg::MODE_OFF;
   assign core_forced_pwm = mode_r == rmvc_pkg::MODE_FORCED_PWM;
   assign core_exit_standby_mode_q = exit_mode;
   assign core_rail_control_q = core_rail_control_r;

   // Unmapped addresses read zero and drop reg_hit.
   always_comb
   begin
      rdata_nxt = 8'h00;
      hit_nxt = 1'b0;
      if (is_core_addr(reg_addr))
      begin
         rdata_nxt = core_rail_control_r;
         hit_nxt = 1'b1;
      end
      else if (is_five_addr(reg_addr))
      begin
         rdata_nxt = rmvc_pkg::FIVE_VOLT_RAIL_CONTROL_RST;
         hit_nxt = 1'b1;
      end
   end

   // Read data is held until the next read so a slow bus front end can fetch it late.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rdata_r <= 8'h00;
      else if (reg_rd)
         rdata_r <= rdata_nxt;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         hit_r <= 1'b0;
      else if (reg_rd)
         hit_r <= hit_nxt;
   end

   assign reg_rdata = rdata_r;
   assign reg_hit = hit_r;
endmodule

// ===== sim/rmvc_checker.sv
module rmvc_checker (
   input wire logic clk,
   input wire logic rst,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic standby_n,
   input wire logic core_low_power_override,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [7:0] core_rail_control_q,
   input wire logic [1:0] core_mode_effective,
   input wire logic signed [4:0] core_setpoint_half_pct
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   localparam logic [4:0] NM [4] = '{5'h0A, 5'h00, 5'h1B, 5'h16};
   wire [7:0] q = core_rail_control_q;
   wire wa = reg_addr == 8'h37;
   // Five quiet cycles cover the pin synchroniser plus the registered outputs.
   sequence calm(sb);
      (standby_n == sb && $stable({q, core_low_power_override})) [*5];
   endsequence
   a_rd_core: assert property (reg_rd && wa |=> reg_rdata == $past(q)) else $error("core read");
   a_wr_core: assert property (reg_wr && wa |=> q == $past(reg_wdata)) else $error("core write");
   a_rd_five: assert property (reg_rd && reg_addr == 8'h38 |=> reg_rdata == 8'h2A) else $error("five read");
   a_exit_copy: assert property ($rose(standby_n) && q[3:2] != 2'h0 |-> ##[3:4] q[1:0] == q[3:2]) else $error("exit");
   a_sp_norm: assert property (calm(1'h1) |-> core_setpoint_half_pct == NM[q[5:4]]) else $error("set point");
   a_sp_low: assert property (calm(1'h0) ##0 q[7:6] != 2'h0 |-> core_setpoint_half_pct == 5'h16 + {q[7:6], 1'h0})
      else $error("low point");
   a_mode_norm: assert property (calm(1'h1) |-> core_mode_effective == q[1:0]) else $error("mode");
   a_force_auto: assert property (calm(1'h0) ##0 (!core_low_power_override && q[1:0] == 2'h3)
      |-> core_mode_effective == 2'h2) else $error("auto");
   c_exit: cover property ($rose(standby_n));
   c_low: cover property (calm(1'h0));
   c_five: cover property (reg_wr && reg_addr == 8'h38);
endmodule

// ===== sim/rmvc_host.sv
module rmvc_host (
   input wire logic clk,
   input wire logic [7:0] reg_rdata,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
   // An idle bus shows inverted values so stale data is never mistaken for a request.
   task automatic xfer(bit wr, logic [7:0] a, d, output logic [7:0] r);
      @(negedge clk);
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {wr, !wr, a, d};
      @(negedge clk);
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h0, ~a, ~d};
      r = reg_rdata;
   endtask
endmodule

// ===== sim/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, standby_n = 1, core_low_power_override = 1, reg_wr, reg_rd;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, core_rail_control_q, r;
   logic [1:0] core_mode_effective, core_exit_standby_mode_q;
   logic reg_hit, core_converter_enable, core_forced_pwm;
   logic signed [4:0] core_setpoint_half_pct;
   localparam logic [7:0] NM [4] = '{8'h0A, 8'h00, 8'h1B, 8'h16};
   int err_count = 0, checks_done = 0;
   rmvc_regs i_rmvc_regs (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .standby_n(standby_n),
      .core_low_power_override(core_low_power_override), .core_mode_effective(core_mode_effective),
      .core_converter_enable(core_converter_enable), .core_forced_pwm(core_forced_pwm),
      .core_setpoint_half_pct(core_setpoint_half_pct), .core_exit_standby_mode_q(core_exit_standby_mode_q),
      .core_rail_control_q(core_rail_control_q));
   rmvc_host i_rmvc_host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd));
   initial forever #5 clk = ~clk;
   task automatic chk(string n, logic [7:0] e, g);
      checks_done++;
      err_count += int'(g !== e);
      if (g !== e) $display("unexpected %s: expected %h, seen %h", n, e, g);
   endtask
   task automatic rdc(logic [7:0] a, e);
      i_rmvc_host.xfer(1'h0, a, 8'h00, r);
      chk("read", e, r);
   endtask
   task automatic t_regs();
      chk("core reset", 8'h0A, core_rail_control_q);
      rdc(8'h38, 8'h2A);
      chk("five hit", 8'h01, {7'h00, reg_hit});
      i_rmvc_host.xfer(1'h1, 8'h38, 8'h00, r);
      rdc(8'h38, 8'h2A);
      i_rmvc_host.xfer(1'h1, 8'h37, 8'hC5, r);
      rdc(8'h37, 8'hC5);
      rdc(8'h39, 8'h00);
      chk("miss hit", 8'h00, {7'h00, reg_hit});
      $display("register test done");
   endtask
   task automatic t_standby();
      for (int v = 0; v < 4; v++)
      begin
         i_rmvc_host.xfer(1'h1, 8'h37, 8'(v * 84 + 3 - v), r);
         repeat (5) @(negedge clk);
         chk("set point", NM[v], {3'h0, core_setpoint_half_pct});
         chk("exit field", 8'(v), {6'h00, core_exit_standby_mode_q});
         {standby_n, core_low_power_override} = 2'h0;
         repeat (5) @(negedge clk);
         chk("low point", v == 0 ? NM[0] : 8'(22 + 2 * v), {3'h0, core_setpoint_half_pct});
         chk("low mode", 8'(v == 0 ? 2 : 3 - v), {6'h00, core_mode_effective});
         chk("converter on", 8'(v != 3), {7'h00, core_converter_enable});
         {standby_n, core_low_power_override} = 2'h3;
         repeat (5) @(negedge clk);
         chk("exit mode", 8'(v == 0 ? 3 : v), {6'h00, core_mode_effective});
         chk("forced pwm", 8'(v == 0 || v == 3), {7'h00, core_forced_pwm});
      end
      $display("standby test done");
   endtask
   task automatic t_reset();
      i_rmvc_host.xfer(1'h1, 8'h37, 8'h55, r);
      rdc(8'h37, 8'h55);
      @(negedge clk);
      rst = 1;
      repeat (2) @(negedge clk);
      rst = 0;
      chk("core reset again", 8'h0A, core_rail_control_q);
      chk("mode reset", 8'h02, {6'h00, core_mode_effective});
      chk("set point reset", 8'h0A, {3'h0, core_setpoint_half_pct});
      chk("hit reset", 8'h00, {7'h00, reg_hit});
      rdc(8'h37, 8'h0A);
      $display("reset test done");
   endtask
   task automatic close_out();
      $display("checks %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(negedge clk);
      rst = 0;
      t_regs();
      t_standby();
      t_reset();
      close_out();
   end
endmodule
bind rmvc_regs rmvc_checker i_rmvc_checker (.clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_wr(reg_wr),
   .standby_n(standby_n), .core_low_power_override(core_low_power_override), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .core_rail_control_q(core_rail_control_q),
   .core_mode_effective(core_mode_effective), .core_setpoint_half_pct(core_setpoint_half_pct));
